// file: sfc_strap_defaults.sv
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
// Summary of operation
// - Port 2 backpressure enable resets to its strap value.
// - Port 2 tx and rx pause enables reset to pause strap; used only when manual.
// - Manual strap low: flow from auto-negotiation, symmetric pause advertised set.
// - Manual strap high: flow from tx/rx pause bits, symmetric pause advertised cleared.
// - External port falls back to strap speed when virtual negotiation fails.
// - Speed strap, duplex polarity and duplex pin form partner ability value.
// - Duplex pin equal to polarity strap means full duplex, else half.
// - External port backpressure enable resets to its strap value.
// - Loader writes after strap capture override the flow-control and advertisement defaults, not the speed or duplex polarity straps.
module sfc_strap_defaults
  import sfc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire sfc_strap_t        strap_pins,
  input  wire logic              mii_duplex_pin,
  input  wire logic              an_enable,
  input  wire logic              an_pause_tx,
  input  wire logic              an_pause_rx,
  input  wire logic              ext_vauto_fail,
  input  wire logic              ext_vauto_speed_100,
  input  wire sfc_req_t          host_req,
  input  wire sfc_load_t         loader_req,
  output logic [DATA_W-1:0]      host_rdata,
  output logic                   straps_loaded,
  output logic                   p2_tx_pause_active,
  output logic                   p2_rx_pause_active,
  output logic                   p2_backpressure_active,
  output logic                   ext_speed_100,
  output logic                   ext_full_duplex,
  output logic                   ext_backpressure_active,
  output logic [DATA_W-1:0]      phy_advertise
);

  sfc_strap_t        strap_meta_r;
  sfc_strap_t        strap_sync_r;
  logic              dup_meta_r;
  logic              dup_sync_r;

  sfc_state_t        state_r;
  sfc_state_t        state_nxt;
  logic [1:0]        cnt_r;
  logic [1:0]        cnt_nxt;
  sfc_strap_t        cap_r;
  sfc_strap_t        cap_nxt;
  logic [DATA_W-1:0] p2_fc_r;
  logic [DATA_W-1:0] p2_fc_nxt;
  logic [DATA_W-1:0] ext_fc_r;
  logic [DATA_W-1:0] ext_fc_nxt;
  logic [DATA_W-1:0] adv_r;
  logic [DATA_W-1:0] adv_nxt;
  logic [DATA_W-1:0] partner_r;
  logic [DATA_W-1:0] partner_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic [DATA_W-1:0] status_w;
  logic              loaded_r;
  logic              loaded_nxt;
  logic              p2_tx_r;
  logic              p2_tx_nxt;
  logic              p2_rx_r;
  logic              p2_rx_nxt;
  logic              p2_bp_r;
  logic              p2_bp_nxt;
  logic              ext_spd_r;
  logic              ext_spd_nxt;
  logic              ext_fd_r;
  logic              ext_fd_nxt;
  logic              ext_bp_r;
  logic              ext_bp_nxt;

  logic              wr_en   [2];
  logic [ADDR_W-1:0] wr_addr [2];
  logic [DATA_W-1:0] wr_data [2];

  // Strap pins and the duplex pin come from the board, so they are synchronised first.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_meta_r <= '0;
      strap_sync_r <= '0;
      dup_meta_r   <= 1'b0;
      dup_sync_r   <= 1'b0;
    end else begin
      strap_meta_r <= strap_pins;
      strap_sync_r <= strap_meta_r;
      dup_meta_r   <= mii_duplex_pin;
      dup_sync_r   <= dup_meta_r;
    end
  end

  // Index 1 is the loader, applied last so it wins a same-address collision.
  assign wr_en[0]   = host_req.wr;
  assign wr_addr[0] = host_req.addr;
  assign wr_data[0] = host_req.wdata;
  assign wr_en[1]   = loader_req.wr;
  assign wr_addr[1] = loader_req.addr;
  assign wr_data[1] = loader_req.wdata;

  always_comb begin
    status_w                 = '0;
    status_w[ST_LOADED_BIT]  = loaded_r;
    status_w[ST_P2_TX_BIT]   = p2_tx_r;
    status_w[ST_P2_RX_BIT]   = p2_rx_r;
    status_w[ST_P2_BP_BIT]   = p2_bp_r;
    status_w[ST_EXT_SPD_BIT] = ext_spd_r;
    status_w[ST_EXT_FD_BIT]  = ext_fd_r;
    status_w[ST_EXT_BP_BIT]  = ext_bp_r;
  end

  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    cap_nxt    = cap_r;
    p2_fc_nxt  = p2_fc_r;
    ext_fc_nxt = ext_fc_r;
    adv_nxt    = adv_r;
    loaded_nxt = loaded_r;
    unique case (state_r)
      SFC_SYNC: begin
        if (cnt_r == SYNC_CYCLES - 2'd1) begin
          state_nxt = SFC_LOAD;
        end else begin
          cnt_nxt = cnt_r + 2'd1;
        end
      end
      SFC_LOAD: begin
        cap_nxt                   = strap_sync_r;
        p2_fc_nxt                 = FC_RESET;
        p2_fc_nxt[FC_BP_BIT]      = strap_sync_r.p2_backpressure_strap;
        p2_fc_nxt[FC_TX_BIT]      = strap_sync_r.p2_pause_enable_strap;
        p2_fc_nxt[FC_RX_BIT]      = strap_sync_r.p2_pause_enable_strap;
        p2_fc_nxt[FC_MANUAL_BIT]  = strap_sync_r.p2_manual_flow_strap;
        adv_nxt                   = ADV_RESET;
        adv_nxt[ADV_SYM_PAUSE_BIT] = ~strap_sync_r.p2_manual_flow_strap;
        ext_fc_nxt                = FC_RESET;
        ext_fc_nxt[FC_BP_BIT]     = strap_sync_r.ext_backpressure_strap;
        loaded_nxt                = 1'b1;
        state_nxt                 = SFC_RUN;
      end
      SFC_RUN: begin
        // Writes only land once the strap defaults are in place.
        for (int i = 0; i < 2; i++) begin
          if (wr_en[i]) begin
            if (wr_addr[i] == REG_P2_FC) begin
              p2_fc_nxt = wr_data[i] & P2_FC_MASK;
            end
            if (wr_addr[i] == REG_EXT_FC) begin
              ext_fc_nxt = wr_data[i] & EXT_FC_MASK;
            end
            if (wr_addr[i] == REG_ADV) begin
              adv_nxt = wr_data[i];
            end
          end
        end
      end
      default: begin
        state_nxt = SFC_SYNC;
      end
    endcase
  end

  always_comb begin
    // Pause enables count only under manual selection; otherwise the negotiation result.
    if (p2_fc_r[FC_MANUAL_BIT]) begin
      p2_tx_nxt = p2_fc_r[FC_TX_BIT];
      p2_rx_nxt = p2_fc_r[FC_RX_BIT];
    end else begin
      p2_tx_nxt = an_enable & an_pause_tx;
      p2_rx_nxt = an_enable & an_pause_rx;
    end
    p2_bp_nxt   = p2_fc_r[FC_BP_BIT];
    ext_bp_nxt  = ext_fc_r[FC_BP_BIT];
    ext_fd_nxt  = (dup_sync_r == cap_r.ext_duplex_pol_strap);
    ext_spd_nxt = ext_vauto_fail ? cap_r.ext_speed_strap : ext_vauto_speed_100;
    partner_nxt = PARTNER_BASE;
    unique case ({cap_r.ext_speed_strap, ext_fd_nxt})
      2'b11:   partner_nxt[ABIL_100FD_BIT] = 1'b1;
      2'b10:   partner_nxt[ABIL_100HD_BIT] = 1'b1;
      2'b01:   partner_nxt[ABIL_10FD_BIT]  = 1'b1;
      default: partner_nxt[ABIL_10HD_BIT]  = 1'b1;
    endcase
    rdata_nxt = '0;
    if (host_req.rd) begin
      unique case (host_req.addr)
        REG_P2_FC:   rdata_nxt = p2_fc_r;
        REG_EXT_FC:  rdata_nxt = ext_fc_r;
        REG_ADV:     rdata_nxt = adv_r;
        REG_PARTNER: rdata_nxt = partner_r;
        REG_STATUS:  rdata_nxt = status_w;
        default:     rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= SFC_SYNC;
      cnt_r     <= 2'd0;
      cap_r     <= '0;
      p2_fc_r   <= FC_RESET;
      ext_fc_r  <= FC_RESET;
      adv_r     <= ADV_RESET;
      partner_r <= PARTNER_BASE;
      rdata_r   <= '0;
      loaded_r  <= 1'b0;
      p2_tx_r   <= 1'b0;
      p2_rx_r   <= 1'b0;
      p2_bp_r   <= 1'b0;
      ext_spd_r <= 1'b0;
      ext_fd_r  <= 1'b0;
      ext_bp_r  <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      cap_r     <= cap_nxt;
      p2_fc_r   <= p2_fc_nxt;
      ext_fc_r  <= ext_fc_nxt;
      adv_r     <= adv_nxt;
      partner_r <= partner_nxt;
      rdata_r   <= rdata_nxt;
      loaded_r  <= loaded_nxt;
      p2_tx_r   <= p2_tx_nxt;
      p2_rx_r   <= p2_rx_nxt;
      p2_bp_r   <= p2_bp_nxt;
      ext_spd_r <= ext_spd_nxt;
      ext_fd_r  <= ext_fd_nxt;
      ext_bp_r  <= ext_bp_nxt;
    end
  end

  assign host_rdata              = rdata_r;
  assign straps_loaded           = loaded_r;
  assign p2_tx_pause_active      = p2_tx_r;
  assign p2_rx_pause_active      = p2_rx_r;
  assign p2_backpressure_active  = p2_bp_r;
  assign ext_speed_100           = ext_spd_r;
  assign ext_full_duplex         = ext_fd_r;
  assign ext_backpressure_active = ext_bp_r;
  assign phy_advertise           = adv_r;

  default clocking chk_clk @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  chk_p2_bp_default: assert property (
    state_r == SFC_LOAD |=> p2_fc_r[FC_BP_BIT] == $past(strap_sync_r.p2_backpressure_strap)
  ) else $error("port 2 backpressure default differs from strap");

  chk_p2_pause_default: assert property (
    state_r == SFC_LOAD |=> (p2_fc_r[FC_TX_BIT] == $past(strap_sync_r.p2_pause_enable_strap))
      && (p2_fc_r[FC_RX_BIT] == p2_fc_r[FC_TX_BIT])
  ) else $error("port 2 pause defaults differ from strap");

  chk_p2_manual_use: assert property (
    state_r == SFC_RUN && p2_fc_r[FC_MANUAL_BIT] && $stable(p2_fc_r)
      |=> p2_tx_pause_active == $past(p2_fc_r[FC_TX_BIT])
        && p2_rx_pause_active == $past(p2_fc_r[FC_RX_BIT])
  ) else $error("manual pause bits not applied");

  chk_adv_pause_set: assert property (
    state_r == SFC_LOAD && !strap_sync_r.p2_manual_flow_strap
      |=> adv_r[ADV_SYM_PAUSE_BIT] && !p2_fc_r[FC_MANUAL_BIT]
  ) else $error("symmetric pause not advertised with auto flow control");

  chk_adv_pause_clear: assert property (
    state_r == SFC_LOAD && strap_sync_r.p2_manual_flow_strap
      |=> !adv_r[ADV_SYM_PAUSE_BIT] && p2_fc_r[FC_MANUAL_BIT]
  ) else $error("symmetric pause advertised with manual flow control");

  chk_ext_fallback: assert property (
    state_r == SFC_RUN && ext_vauto_fail |=> ext_speed_100 == cap_r.ext_speed_strap
  ) else $error("fallback speed does not follow strap");

  chk_partner_ability: assert property (
    state_r == SFC_RUN && $stable(dup_sync_r) ##1 $stable(dup_sync_r)
      |=> partner_r[ABIL_100FD_BIT] == (cap_r.ext_speed_strap && ext_full_duplex)
        && partner_r[ABIL_10HD_BIT] == (!cap_r.ext_speed_strap && !ext_full_duplex)
  ) else $error("partner ability disagrees with speed and duplex");

  chk_ext_duplex: assert property (
    state_r == SFC_RUN && $changed(mii_duplex_pin)
      |-> ##3 ext_full_duplex == ($past(mii_duplex_pin, 3) == cap_r.ext_duplex_pol_strap)
  ) else $error("duplex does not follow pin against polarity");

  chk_ext_bp_default: assert property (
    state_r == SFC_LOAD |=> ext_fc_r[FC_BP_BIT] == $past(strap_sync_r.ext_backpressure_strap)
      ##1 ext_backpressure_active == ext_fc_r[FC_BP_BIT] || $changed(ext_fc_r)
  ) else $error("external backpressure default differs from strap");

  chk_loader_override: assert property (
    state_r == SFC_RUN && loader_req.wr && loader_req.addr == REG_P2_FC
      |=> p2_fc_r == ($past(loader_req.wdata) & P2_FC_MASK)
  ) else $error("loader write did not override default");

  chk_strap_hold: assert property (
    state_r == SFC_RUN |=> state_r == SFC_RUN && $stable(cap_r) && straps_loaded
  ) else $error("captured straps changed after load");

endmodule : sfc_strap_defaults

// file: sfc_pkg.sv
package sfc_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register offsets (word index on the plain register port).
  localparam logic [ADDR_W-1:0] REG_P2_FC   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_EXT_FC  = 4'h1;
  localparam logic [ADDR_W-1:0] REG_ADV     = 4'h2;
  localparam logic [ADDR_W-1:0] REG_PARTNER = 4'h3;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 4'h4;

  // Manual flow-control register fields (port 2; the external port keeps only the backpressure bit).
  localparam int FC_BP_BIT     = 0;
  localparam int FC_RX_BIT     = 1;
  localparam int FC_TX_BIT     = 2;
  localparam int FC_MANUAL_BIT = 3;
  localparam logic [DATA_W-1:0] P2_FC_MASK  = 16'h000f;
  localparam logic [DATA_W-1:0] EXT_FC_MASK = 16'h0001;
  localparam logic [DATA_W-1:0] FC_RESET    = 16'h0000;

  // Advertisement and partner ability fields.
  localparam int ADV_SYM_PAUSE_BIT = 10;
  localparam int ABIL_10HD_BIT     = 5;
  localparam int ABIL_10FD_BIT     = 6;
  localparam int ABIL_100HD_BIT    = 7;
  localparam int ABIL_100FD_BIT    = 8;
  localparam logic [DATA_W-1:0] ADV_RESET     = 16'h0001;
  localparam logic [DATA_W-1:0] PARTNER_BASE  = 16'h0001;

  // Status register fields.
  localparam int ST_LOADED_BIT = 0;
  localparam int ST_P2_TX_BIT  = 1;
  localparam int ST_P2_RX_BIT  = 2;
  localparam int ST_P2_BP_BIT  = 3;
  localparam int ST_EXT_SPD_BIT = 4;
  localparam int ST_EXT_FD_BIT = 5;
  localparam int ST_EXT_BP_BIT = 6;

  // Cycles spent after reset release before the synchronised straps are taken.
  localparam logic [1:0] SYNC_CYCLES = 2'd2;

  typedef struct packed {
    logic p2_backpressure_strap;
    logic p2_pause_enable_strap;
    logic p2_manual_flow_strap;
    logic ext_speed_strap;
    logic ext_duplex_pol_strap;
    logic ext_backpressure_strap;
  } sfc_strap_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } sfc_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
  } sfc_load_t;

  typedef enum logic [1:0] {
    SFC_SYNC,
    SFC_LOAD,
    SFC_RUN
  } sfc_state_t;

endpackage : sfc_pkg

// file: sfc_board_model.sv
`timescale 1ns/100ps
// Board straps, the external duplex pin and the configuration loader.
module sfc_board_model
  import sfc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       straps_loaded,
  input  wire sfc_strap_t strap_set,
  input  wire logic       pin_set,
  input  wire sfc_load_t  load_cmd,
  output sfc_strap_t      strap_pins,
  output logic            mii_duplex_pin,
  output sfc_load_t       loader_req
);
  assign strap_pins     = strap_set;
  assign mii_duplex_pin = pin_set;

  // The loader only issues a write once the device has taken its straps.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      loader_req <= '0;
    end else begin
      loader_req <= {load_cmd.addr, load_cmd.wdata, load_cmd.wr & straps_loaded};
    end
  end
endmodule : sfc_board_model

// file: sfc_tb.sv
`timescale 1ns/100ps
module tb;
  import sfc_pkg::*;
  logic              ref_clk;
  logic              reset_n;
  sfc_strap_t        strap_set;
  sfc_strap_t        cur;
  logic              pin_set;
  sfc_load_t         load_cmd;
  logic              an_enable;
  logic              an_pause_tx;
  logic              an_pause_rx;
  logic              ext_vauto_fail;
  logic              ext_vauto_speed_100;
  sfc_req_t          host_req;
  sfc_strap_t        strap_pins;
  logic              mii_duplex_pin;
  sfc_load_t         loader_req;
  logic [DATA_W-1:0] host_rdata;
  logic [DATA_W-1:0] phy_advertise;
  wire [6:0]         outs;
  logic [31:0]       lfsr;
  int                n_errors;
  int                checks;

  sfc_board_model i_board (.ref_clk(ref_clk), .reset_n(reset_n), .straps_loaded(outs[0]),
    .strap_set(strap_set), .pin_set(pin_set), .load_cmd(load_cmd), .strap_pins(strap_pins),
    .mii_duplex_pin(mii_duplex_pin), .loader_req(loader_req));

  sfc_strap_defaults i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .strap_pins(strap_pins),
    .mii_duplex_pin(mii_duplex_pin), .an_enable(an_enable), .an_pause_tx(an_pause_tx),
    .an_pause_rx(an_pause_rx), .ext_vauto_fail(ext_vauto_fail),
    .ext_vauto_speed_100(ext_vauto_speed_100), .host_req(host_req), .loader_req(loader_req),
    .host_rdata(host_rdata), .straps_loaded(outs[0]), .p2_tx_pause_active(outs[1]),
    .p2_rx_pause_active(outs[2]), .p2_backpressure_active(outs[3]), .ext_speed_100(outs[4]),
    .ext_full_duplex(outs[5]), .ext_backpressure_active(outs[6]),
    .phy_advertise(phy_advertise));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  function automatic logic [15:0] exp_status(input logic [15:0] p2, input logic ebp,
                                             input logic fd, input logic spd);
    logic tx;
    logic rx;
    tx = p2[3] ? p2[2] : (an_enable & an_pause_tx);
    rx = p2[3] ? p2[1] : (an_enable & an_pause_rx);
    return {9'h000, ebp, fd, spd, p2[0], rx, tx, 1'b1};
  endfunction : exp_status

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic report_and_stop;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    host_req <= {a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    host_req <= '0;
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    host_req <= {a, 16'h0000, 1'b0, 1'b1};
    @(posedge ref_clk);
    host_req <= '0;
    #1 cmp_word(host_rdata, e);
  endtask : bus_rd

  task automatic ld_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    load_cmd <= {a, d, 1'b1};
    @(posedge ref_clk);
    load_cmd <= '0;
    repeat (3) @(posedge ref_clk);
  endtask : ld_wr

  task automatic check_all(input logic [15:0] p2, input logic ebp, input logic [15:0] adv);
    logic        fd;
    logic        spd;
    logic [15:0] pa;
    fd = (pin_set == cur.ext_duplex_pol_strap);
    spd = ext_vauto_fail ? cur.ext_speed_strap : ext_vauto_speed_100;
    pa = PARTNER_BASE;
    pa[cur.ext_speed_strap ? (fd ? ABIL_100FD_BIT : ABIL_100HD_BIT)
                           : (fd ? ABIL_10FD_BIT : ABIL_10HD_BIT)] = 1'b1;
    bus_rd(REG_P2_FC, p2);
    bus_rd(REG_EXT_FC, {15'h0000, ebp});
    bus_rd(REG_ADV, adv);
    bus_rd(REG_PARTNER, pa);
    bus_rd(REG_STATUS, exp_status(p2, ebp, fd, spd));
    cmp_word({9'h000, outs}, exp_status(p2, ebp, fd, spd));
    cmp_word(phy_advertise, adv);
  endtask : check_all

  initial begin
    reset_n = 1'b0;
    strap_set = '0;
    pin_set = 1'b0;
    load_cmd = '0;
    host_req = '0;
    {an_enable, an_pause_tx, an_pause_rx, ext_vauto_fail, ext_vauto_speed_100} = '0;
    lfsr = 32'hec08;
    for (int it = 0; it < 10; it++) begin
      lfsr = lfsr_next(lfsr);
      cur = (it == 0) ? 6'h00 : (it == 1) ? 6'h3f : lfsr[5:0];
      @(posedge ref_clk);
      reset_n <= 1'b0;
      strap_set <= cur;
      pin_set <= lfsr[6];
      {an_enable, an_pause_tx, an_pause_rx, ext_vauto_fail, ext_vauto_speed_100} <= lfsr[11:7];
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      // A write before the straps are taken must be dropped.
      bus_wr(REG_P2_FC, 16'hffff);
      for (int w = 0; w < 20 && outs[0] !== 1'b1; w++) @(negedge ref_clk);
      if (outs[0] !== 1'b1) begin
        n_errors++;
        $display("FAIL %0t straps never taken", $time);
        report_and_stop();
      end
      repeat (2) @(posedge ref_clk);
      check_all({12'h000, cur.p2_manual_flow_strap, {2{cur.p2_pause_enable_strap}},
                 cur.p2_backpressure_strap}, cur.ext_backpressure_strap,
                ADV_RESET | {5'h00, ~cur.p2_manual_flow_strap, 10'h000});
      // Later strap changes are ignored; the duplex pin is followed.
      @(posedge ref_clk);
      strap_set <= ~cur;
      pin_set <= ~pin_set;
      repeat (6) @(posedge ref_clk);
      check_all({12'h000, cur.p2_manual_flow_strap, {2{cur.p2_pause_enable_strap}},
                 cur.p2_backpressure_strap}, cur.ext_backpressure_strap,
                ADV_RESET | {5'h00, ~cur.p2_manual_flow_strap, 10'h000});
    end
    ld_wr(REG_ADV, 16'h0000);
    ld_wr(REG_P2_FC, 16'hffff);
    ld_wr(REG_EXT_FC, {15'h0000, ~cur.ext_backpressure_strap});
    bus_wr(REG_STATUS, 16'hffff);
    bus_rd(4'h5, 16'h0000);
    repeat (2) @(posedge ref_clk);
    check_all(16'h000f, ~cur.ext_backpressure_strap, 16'h0000);
    bus_wr(REG_P2_FC, 16'h0008);
    bus_wr(REG_EXT_FC, {15'h0000, cur.ext_backpressure_strap});
    repeat (2) @(posedge ref_clk);
    check_all(16'h0008, cur.ext_backpressure_strap, 16'h0000);
    report_and_stop();
  end
endmodule : tb
